// *** verilog/dosc_output_ctrl.sv ***
// output state, lock flag, spread profile, fallback clock and slew control
// assumes the serial front end delivers words on the recovered link clock;
// the fallback clock is built from the reference clock and pins are synced
`timescale 1ns/1ns

module dosc_output_ctrl (
	// clocks and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic link_clk_i,
	// link side words on the recovered clock
	input wire logic [dosc_pkg::DATA_W-1:0] link_data_i,
	input wire logic [dosc_pkg::CTRL_W-1:0] link_ctrl_i,
	// configuration pins
	input wire logic power_down_n_i,
	input wire logic unlocked_output_state_sel_i,
	input wire logic data_slew_sel_i,
	input wire logic clock_slew_sel_i,
	input wire logic [dosc_pkg::SSC_W-1:0] spread_cfg_code_i,
	input wire logic low_freq_range_sel_i,
	input wire logic [dosc_pkg::OSC_SEL_W-1:0] fallback_osc_freq_sel_i,
	input wire logic [dosc_pkg::PIN_W-1:0] strap_i,
	// parallel outputs
	output logic [dosc_pkg::DATA_W-1:0] data_o,
	output logic data_oe_o,
	output logic [dosc_pkg::CTRL_W-1:0] control_bits_out_o,
	output logic control_oe_o,
	output logic [dosc_pkg::PIN_W-1:0] pullup_o,
	// clock output
	output logic recovered_clock_out_o,
	output logic clock_oe_o,
	// status pins
	output logic lock_o,
	output logic lock_oe_o,
	output logic pass_o,
	output logic pass_oe_o,
	// pad drive strength
	output logic data_slew_fast_o,
	output logic clock_slew_fast_o,
	// spread profile to the output clock synthesiser
	output logic ssc_on_o,
	output logic [1:0] ssc_dev_o,
	output logic [dosc_pkg::MOD_W-1:0] ssc_phase_o
);
	import dosc_pkg::*;

	// ----------------------------------------------------------------
	// reference domain state
	// ----------------------------------------------------------------
	typedef struct packed {
		dosc_state_e st;
		logic linked;
		logic pd_m, pd_s;
		logic oss_m, oss_s;
		logic ds_m, ds_s;
		logic cs_m, cs_s;
		logic [OSC_SEL_W-1:0] osel_m, osel_s;
		logic [PIN_W-1:0] strap_m, strap_s, strap_cap;
		logic act_m, act_s, act_d;
		logic [IDLE_W-1:0] idle;
		logic [LOCK_W-1:0] lock_cnt;
		logic [OSC_CNT_W-1:0] osc_cnt;
		logic osc_clk, osc_gate;
		logic lg_m, lg_s;
		logic dfast, cfast;
	} dosc_ref_s;

	// ----------------------------------------------------------------
	// link domain state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [ACT_DIV_W-1:0] div_cnt;
		logic lock_m, lock_s;
		logic want_m, want_s;
		logic og_m, og_s;
		logic [SSC_W-1:0] code_m, code_s;
		logic lf_m, lf_s;
		logic [DATA_W-1:0] data;
		logic [CTRL_W-1:0] ctrl;
		logic [MOD_W-1:0] mod_cnt, phase;
		logic on;
		logic [1:0] dev;
	} dosc_link_s;

	dosc_ref_s r_r, r_nxt;
	dosc_link_s l_r, l_nxt;
	logic link_gate_r;
	logic dead;
	logic want_osc;
	logic [SSC_W-1:0] code_m1;
	logic [MOD_W-1:0] div;

	assign dead = (r_r.idle >= IDLE_W'(LOSS_CYC));
	assign want_osc = (r_r.st == ST_ACQ) && (r_r.osel_s != OSC_OFF);

	always_comb begin
		r_nxt = r_r;
		r_nxt.pd_m = power_down_n_i;
		r_nxt.pd_s = r_r.pd_m;
		r_nxt.oss_m = unlocked_output_state_sel_i;
		r_nxt.oss_s = r_r.oss_m;
		r_nxt.ds_m = data_slew_sel_i;
		r_nxt.ds_s = r_r.ds_m;
		r_nxt.cs_m = clock_slew_sel_i;
		r_nxt.cs_s = r_r.cs_m;
		r_nxt.osel_m = fallback_osc_freq_sel_i;
		r_nxt.osel_s = r_r.osel_m;
		r_nxt.strap_m = strap_i;
		r_nxt.strap_s = r_r.strap_m;
		r_nxt.act_m = l_r.div_cnt[ACT_DIV_W-1];
		r_nxt.act_s = r_r.act_m;
		r_nxt.act_d = r_r.act_s;
		r_nxt.lg_m = link_gate_r;
		r_nxt.lg_s = r_r.lg_m;
		r_nxt.dfast = r_r.ds_s;
		r_nxt.cfast = r_r.cs_s;
		// activity watchdog on the divided link clock
		if (r_r.act_s != r_r.act_d) begin
			r_nxt.idle = '0;
		end else if (!dead) begin
			r_nxt.idle = r_r.idle + IDLE_W'(1);
		end
		case (r_r.st)
			ST_OFF: begin
				// straps are only recognised while powered down
				r_nxt.strap_cap = r_r.strap_s;
				r_nxt.lock_cnt = '0;
				if (r_r.pd_s) begin
					r_nxt.st = ST_ACQ;
				end
			end
			ST_ACQ: begin
				if (dead) begin
					r_nxt.lock_cnt = '0;
				end else if (r_r.lock_cnt == LOCK_W'(LOCK_CYC - 1)) begin
					r_nxt.st = ST_LOCKED;
				end else begin
					r_nxt.lock_cnt = r_r.lock_cnt + LOCK_W'(1);
				end
			end
			ST_LOCKED: begin
				if (dead) begin
					r_nxt.st = ST_ACQ;
					r_nxt.lock_cnt = '0;
				end
			end
			default: begin
				r_nxt.st = ST_OFF;
			end
		endcase
		if (!r_r.pd_s) begin
			r_nxt.st = ST_OFF;
		end
		r_nxt.linked = (r_nxt.st == ST_LOCKED);
		if (r_r.osc_cnt >= osc_half(r_r.osel_s) - OSC_CNT_W'(1)) begin
			r_nxt.osc_cnt = '0;
			r_nxt.osc_clk = ~r_r.osc_clk;
		end else begin
			r_nxt.osc_cnt = r_r.osc_cnt + OSC_CNT_W'(1);
		end
		// gate opens on a rising and closes on a falling edge
		if (!r_r.osc_clk && r_nxt.osc_clk && want_osc && !r_r.lg_s) begin
			r_nxt.osc_gate = 1'b1;
		end else if (r_r.osc_clk && !r_nxt.osc_clk && !want_osc) begin
			r_nxt.osc_gate = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			r_r <= '{st: ST_OFF, default: '0};
		end else begin
			r_r <= r_nxt;
		end
	end

	// ----------------------------------------------------------------
	// link domain
	// ----------------------------------------------------------------
	assign code_m1 = l_r.code_s - SSC_W'(1);
	// rate per range and code group
	assign div = ssc_div(l_r.lf_s, code_m1[3:2]);

	always_comb begin
		l_nxt = l_r;
		l_nxt.div_cnt = l_r.div_cnt + ACT_DIV_W'(1);
		l_nxt.lock_m = r_r.linked;
		l_nxt.lock_s = l_r.lock_m;
		l_nxt.want_m = r_r.linked;
		l_nxt.want_s = l_r.want_m;
		l_nxt.og_m = r_r.osc_gate;
		l_nxt.og_s = l_r.og_m;
		l_nxt.code_m = spread_cfg_code_i;
		l_nxt.code_s = l_r.code_m;
		l_nxt.lf_m = low_freq_range_sel_i;
		l_nxt.lf_s = l_r.lf_m;
		l_nxt.data = link_data_i;
		l_nxt.ctrl = link_ctrl_i;
		// spread only while locked and coded on
		l_nxt.on = l_r.lock_s && (l_r.code_s != SSC_OFF);
		// deviation cycles in half percent steps
		l_nxt.dev = code_m1[1:0];
		if (!l_r.on) begin
			l_nxt.mod_cnt = '0;
			l_nxt.phase = '0;
		end else begin
			if (l_r.mod_cnt >= div - MOD_W'(1)) begin
				l_nxt.mod_cnt = '0;
			end else begin
				l_nxt.mod_cnt = l_r.mod_cnt + MOD_W'(1);
			end
			// triangle profile, peak at half the period
			if (l_r.mod_cnt < (div >> 1)) begin
				l_nxt.phase = l_r.mod_cnt;
			end else begin
				l_nxt.phase = div - l_r.mod_cnt;
			end
		end
	end

	always_ff @(posedge link_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			l_r <= '0;
		end else begin
			l_r <= l_nxt;
		end
	end

	// link gate changes only while the link clock is low
	// a stopped link clock cannot close it, so loss clears it at once
	always_ff @(negedge link_clk_i or negedge rst_b_i or
		negedge r_r.linked) begin
		if (!rst_b_i) begin
			link_gate_r <= 1'b0;
		end else if (!r_r.linked) begin
			link_gate_r <= 1'b0;
		end else begin
			link_gate_r <= l_r.want_s && !l_r.og_s;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// source mux, both gates never open together
	assign recovered_clock_out_o = (link_clk_i & link_gate_r) |
		(r_r.osc_clk & r_r.osc_gate);
	// forced low by the lock level since the link flops stall on loss
	assign data_o = l_r.data & {DATA_W{r_r.linked}};
	assign control_bits_out_o = l_r.ctrl & {CTRL_W{r_r.linked}};
	assign ssc_on_o = l_r.on;
	assign ssc_dev_o = l_r.dev;
	assign ssc_phase_o = l_r.phase;
	assign data_slew_fast_o = r_r.dfast;
	assign clock_slew_fast_o = r_r.cfast;

	// drive per power-down and state select
	always_comb begin
		data_oe_o = 1'b0;
		clock_oe_o = 1'b0;
		lock_oe_o = 1'b0;
		pass_oe_o = 1'b0;
		lock_o = 1'b0;
		pass_o = 1'b0;
		case (r_r.st)
			ST_ACQ: begin
				data_oe_o = !r_r.oss_s;
				clock_oe_o = !r_r.oss_s || r_r.osc_gate;
				lock_oe_o = 1'b1;
				pass_oe_o = 1'b1;
			end
			ST_LOCKED: begin
				data_oe_o = 1'b1;
				clock_oe_o = 1'b1;
				lock_oe_o = 1'b1;
				pass_oe_o = 1'b1;
				lock_o = 1'b1;
				pass_o = 1'b1;
			end
			default: begin
				data_oe_o = 1'b0;
			end
		endcase
		control_oe_o = data_oe_o;
		// pull up floated pins strapped high
		pullup_o = (r_r.st == ST_ACQ && r_r.oss_s) ? r_r.strap_cap : '0;
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);

	sequence s_pd_fall;
		$fell(r_r.pd_s);
	endsequence
	sequence s_all_float;
		!data_oe_o && !clock_oe_o && !lock_oe_o && !pass_oe_o;
	endsequence
	property p_pd_float;
		s_pd_fall |=> s_all_float;
	endproperty
	a_pd_float: assert property (p_pd_float)
		else $error("outputs not floated after power-down");

	property p_acq_low;
		$rose(r_r.pd_s) |=> lock_oe_o && !lock_o;
	endproperty
	a_acq_low: assert property (p_acq_low)
		else $error("lock not driven low on acquisition start");

	property p_lock_time;
		$rose(lock_o) |-> $past(r_r.lock_cnt) == LOCK_W'(LOCK_CYC - 1);
	endproperty
	a_lock_time: assert property (p_lock_time)
		else $error("lock rose before the lock sequence completed");

	property p_loss;
		lock_o && r_r.idle == IDLE_W'(LOSS_CYC - 1) &&
			r_r.act_s == r_r.act_d && r_r.pd_s ##1 r_r.act_s == r_r.act_d
			|=> !lock_o;
	endproperty
	a_loss: assert property (p_loss)
		else $error("lock stayed high after clock loss");

	property p_static_low;
		(r_r.st == ST_ACQ && !r_r.oss_s) |->
			data_oe_o && data_o == '0 && lock_oe_o && !lock_o && !pass_o;
	endproperty
	a_static_low: assert property (p_static_low)
		else $error("static input with select low not driven low");

	property p_osc_only_unlocked;
		r_r.osc_gate |-> !lock_o || $past(!lock_o, 2);
	endproperty
	a_osc_only_unlocked: assert property (p_osc_only_unlocked)
		else $error("fallback clock driven while locked");

	property p_osc_off;
		(r_r.osel_s == OSC_OFF)[*3] |-> !r_r.osc_gate;
	endproperty
	a_osc_off: assert property (p_osc_off)
		else $error("fallback clock enabled with select zero");

	property p_no_overlap;
		!(link_gate_r && r_r.osc_gate);
	endproperty
	a_no_overlap: assert property (p_no_overlap)
		else $error("both clock sources gated on");

	property p_slew;
		$changed(r_r.ds_s) |=> data_slew_fast_o == $past(r_r.ds_s);
	endproperty
	a_slew: assert property (p_slew)
		else $error("data slew select not applied");

	property p_pullup;
		pullup_o != '0 |-> !data_oe_o && r_r.oss_s;
	endproperty
	a_pullup: assert property (p_pullup)
		else $error("pull-up on a driven pin");

	property p_ssc_off;
		@(posedge link_clk_i) disable iff (!rst_b_i)
		(l_r.code_s == SSC_OFF) |=> !ssc_on_o ##1 ssc_phase_o == '0;
	endproperty
	a_ssc_off: assert property (p_ssc_off)
		else $error("spread active with code zero");

	property p_ssc_period;
		@(posedge link_clk_i) disable iff (!rst_b_i)
		l_r.on && l_nxt.on && l_r.mod_cnt == div - MOD_W'(1) &&
			$stable(l_r.code_s) && $stable(l_r.lf_s) |=> l_r.mod_cnt == '0;
	endproperty
	a_ssc_period: assert property (p_ssc_period)
		else $error("spread period not per selected rate");

endmodule

// *** verilog/dosc_pkg.sv ***
// constants, types and decode helpers for the deserializer output control
// assumes a 25 MHz reference clock and a recovered link clock up to 83.3 MHz
package dosc_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int DATA_W = 24;
	localparam int CTRL_W = 3;
	localparam int PIN_W = DATA_W + CTRL_W;
	localparam int SSC_W = 4;
	localparam int OSC_SEL_W = 3;
	localparam int MOD_W = 12;
	localparam int ACT_DIV_W = 3;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int REF_CLK_KHZ = 25000;
	localparam int LOSS_TIME_NS = 4000;
	localparam int LOCK_TIME_NS = 100000;
	// longest idle time rounds down, least lock time rounds up
	// scaled to MHz first so the products stay inside 32 bits
	localparam int LOSS_CYC = (LOSS_TIME_NS * (REF_CLK_KHZ / 1000)) / 1000;
	localparam int LOCK_CYC = (LOCK_TIME_NS * (REF_CLK_KHZ / 1000) + 999) / 1000;
	localparam int IDLE_W = 8;
	localparam int LOCK_W = 12;
	localparam int OSC_CNT_W = 4;

	// ----------------------------------------------------------------
	// codes
	// ----------------------------------------------------------------
	localparam logic [SSC_W-1:0] SSC_OFF = 4'h0;
	localparam logic [OSC_SEL_W-1:0] OSC_OFF = 3'h0;

	typedef enum logic [1:0] {
		ST_OFF = 2'b00,
		ST_ACQ = 2'b01,
		ST_LOCKED = 2'b10
	} dosc_state_e;

	// modulation period in output clocks, per range and code group
	function automatic logic [MOD_W-1:0] ssc_div(input logic lf,
		input logic [1:0] grp);
		logic [MOD_W-1:0] d;
		d = 12'h878;
		case ({lf, grp})
			3'b000: d = 12'h878;
			3'b001: d = 12'h514;
			3'b010: d = 12'h364;
			3'b011: d = 12'h28A;
			3'b100: d = 12'h26C;
			3'b101: d = 12'h172;
			3'b110: d = 12'h102;
			3'b111: d = 12'h0C0;
			default: d = 12'h878;
		endcase
		return d;
	endfunction

	// nominal fallback frequencies in kHz
	function automatic int osc_khz(input logic [OSC_SEL_W-1:0] sel);
		int f;
		f = 50000;
		case (sel)
			3'h1: f = 50000;
			3'h2: f = 25000;
			3'h3: f = 16700;
			3'h4: f = 12500;
			3'h5: f = 10000;
			3'h6: f = 8300;
			3'h7: f = 6300;
			default: f = 50000;
		endcase
		return f;
	endfunction

	// half period in reference cycles, never below one
	function automatic logic [OSC_CNT_W-1:0] osc_half(
		input logic [OSC_SEL_W-1:0] sel);
		int h;
		h = (REF_CLK_KHZ + 2 * osc_khz(sel) - 1) / (2 * osc_khz(sel));
		if (h < 1) h = 1;
		return OSC_CNT_W'(h);
	endfunction

endpackage

// *** testbench/dosc_ser_model.sv ***
// upstream serializer model: recovered link clock plus 27-bit word
// assumes the bench sets run_i, slow_i and word_i off the link edges
`timescale 1ns/1ns
module dosc_ser_model (
	// control from the bench
	input wire logic run_i,
	input wire logic slow_i,
	input wire logic [dosc_pkg::PIN_W-1:0] word_i,
	// link side
	output logic link_clk_o,
	output logic [dosc_pkg::DATA_W-1:0] data_o,
	output logic [dosc_pkg::CTRL_W-1:0] ctrl_o
);
	import dosc_pkg::*;
	initial begin
		link_clk_o = 1'b0;
		{ctrl_o, data_o} = '0;
		// delay only holds this initial block; the clock loop starts at time zero
		#3;
	end
	// clock stands low while the link is lost; lines keep moving
	always begin
		#(slow_i ? 8 : 6);
		if (run_i) begin
			link_clk_o = ~link_clk_o;
			if (!link_clk_o) {ctrl_o, data_o} = word_i;
		end else begin
			link_clk_o = 1'b0;
			{ctrl_o, data_o} = ~{ctrl_o, data_o};
		end
	end
endmodule

// *** testbench/tb.sv ***
// self-checking bench for the deserializer output control
// assumes dosc_ser_model stands in for the serializer on the link
`timescale 1ns/1ns
module tb;
	import dosc_pkg::*;
	typedef struct {int id; logic [31:0] v;} dosc_note_s;
	logic ref_clk_i = 1'b0, rst_b_i = 1'b0, run = 1'b0, slow = 1'b0;
	logic [PIN_W-1:0] word = '0, strap = '0;
	logic link_clk;
	logic [DATA_W-1:0] ldat, dat;
	logic [CTRL_W-1:0] lctl, ctl;
	logic pdn = 1'b0, oss = 1'b0, dsl = 1'b0, csl = 1'b0, lf = 1'b0;
	logic [SSC_W-1:0] ssc = 4'h0;
	logic [OSC_SEL_W-1:0] osc = 3'h0;
	logic [PIN_W-1:0] pup;
	logic d_oe, c_oe, clk_o, k_oe, lk, lk_oe, ps, ps_oe, dfs, cfs, s_on;
	logic [1:0] s_dev;
	logic [MOD_W-1:0] s_ph;
	logic [31:0] meas = 32'h0;
	int err_total = 0, samples_checked = 0, edges = 0;
	int divs[8] = '{2168, 1300, 868, 650, 620, 370, 258, 192};
	dosc_note_s notes[$];
	event smp;

	always #20 ref_clk_i = ~ref_clk_i;
	always @(posedge clk_o) edges++;

	dosc_ser_model ser (.run_i(run), .slow_i(slow), .word_i(word),
		.link_clk_o(link_clk), .data_o(ldat), .ctrl_o(lctl));
	dosc_output_ctrl DUT (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
		.link_clk_i(link_clk), .link_data_i(ldat), .link_ctrl_i(lctl),
		.power_down_n_i(pdn), .unlocked_output_state_sel_i(oss),
		.data_slew_sel_i(dsl), .clock_slew_sel_i(csl),
		.spread_cfg_code_i(ssc), .low_freq_range_sel_i(lf),
		.fallback_osc_freq_sel_i(osc), .strap_i(strap), .data_o(dat),
		.data_oe_o(d_oe), .control_bits_out_o(ctl), .control_oe_o(c_oe),
		.pullup_o(pup), .recovered_clock_out_o(clk_o), .clock_oe_o(k_oe),
		.lock_o(lk), .lock_oe_o(lk_oe), .pass_o(ps), .pass_oe_o(ps_oe),
		.data_slew_fast_o(dfs), .clock_slew_fast_o(cfs), .ssc_on_o(s_on),
		.ssc_dev_o(s_dev), .ssc_phase_o(s_ph));

	// ----------------------------------------------------------------
	// checking
	// ----------------------------------------------------------------
	function automatic logic [31:0] obs(input int id);
		case (id)
			0: return 32'(lk_oe);
			1: return 32'(lk);
			2: return 32'(d_oe);
			3: return 32'(k_oe);
			4: return 32'(dat);
			5: return 32'(ctl);
			6: return 32'(pup);
			7: return 32'({dfs, cfs});
			8: return 32'(s_on);
			9: return 32'(s_dev);
			10: return 32'(ps_oe);
			11: return 32'(c_oe);
			13: return 32'(ps);
			default: return meas;
		endcase
	endfunction

	always @(smp) begin
		dosc_note_s n;
		while (notes.size() > 0) begin
			n = notes.pop_front();
			samples_checked++;
			if (obs(n.id) !== n.v) begin
				err_total++;
				$display("[ERR] %0t item %0d got %h want %h", $time, n.id,
					obs(n.id), n.v);
			end
		end
	end

	task automatic note(input int id, input logic [31:0] v);
		notes.push_back('{id, v});
	endtask
	task automatic check();
		->smp;
		#1;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask
	task automatic results();
		if (err_total == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// bounded wait; running out ends the run
	task automatic wait_lock(input logic v, input int lim);
		int i;
		for (i = 0; i < lim && lk !== v; i++) tick(1);
		if (lk !== v) begin
			err_total++;
			results();
		end
	endtask
	// rising edges of the clock output over 40 reference cycles
	task automatic count_edges(input int lo, input int hi);
		int e0;
		e0 = edges;
		tick(40);
		meas = 32'((edges - e0 >= lo) && (edges - e0 <= hi));
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		int dv, dev, mx;
		void'($urandom(32'h20892e91));
		strap = PIN_W'($urandom);
		tick(8);
		rst_b_i = 1'b1;
		tick(4);
		note(0, 0); note(2, 0); note(3, 0); note(10, 0); check();
		for (int k = 0; k < 4; k++) begin
			{dsl, csl} = 2'(k);
			tick(4);
			note(7, k); check();
		end
		pdn = 1'b1;
		tick(3);
		note(0, 1); note(1, 0); note(2, 1); note(4, 0); check();
		note(3, 1); note(10, 1); note(13, 0); check();
		word = PIN_W'($urandom);
		run = 1'b1;
		tick(2400);
		note(1, 0); check();
		wait_lock(1'b1, 300);
		note(2, 1); note(3, 1); note(11, 1); note(13, 1); check();
		repeat (4) begin
			word = PIN_W'($urandom);
			tick(4);
			note(4, word[DATA_W-1:0]); note(5, word[PIN_W-1:DATA_W]); check();
		end
		slow = 1'b1;
		for (int g = 0; g < 8; g++) begin
			tick(1);
			ssc = 4'h0;
			tick(8);
			note(8, 0); check();
			dv = divs[g];
			dev = $urandom_range(g % 4 == 3 ? 2 : 3);
			lf = g[2];
			ssc = 4'((g % 4) * 4 + dev + 1);
			tick(10);
			mx = 0;
			for (int e = 0; e < 2 * dv + 8; e++) begin
				@(negedge link_clk);
				if (int'(s_ph) > mx) mx = s_ph;
			end
			meas = 32'(mx);
			note(8, 1); note(9, dev); note(12, dv / 2); check();
			tick(1);
		end
		// spread must be off before the link runs above 65 MHz
		// code zero fast
		ssc = 4'h0;
		slow = 1'b0;
		tick(4);
		oss = 1'b1;
		osc = 3'($urandom_range(7, 1));
		run = 1'b0;
		tick(90);
		note(1, 1); check();
		wait_lock(1'b0, 30);
		note(2, 0); note(11, 0); note(6, strap); check();
		// gate waits for the link gate sync and an oscillator rising edge
		tick(6);
		note(3, 1); note(10, 1); note(13, 0); check();
		tick(4);
		if (osc < 3'h5) count_edges(19, 21);
		else count_edges(9, 11);
		note(12, 1); check();
		osc = 3'h0;
		tick(8);
		note(3, 0); check();
		osc = 3'h3;
		run = 1'b1;
		wait_lock(1'b1, 2700);
		tick(4);
		count_edges(130, 137);
		note(12, 1); note(3, 1); check();
		pdn = 1'b0;
		tick(3);
		note(0, 0); note(2, 0); note(3, 0); note(10, 0); check();
		results();
	end
endmodule
